// >>> hw/exc_entry.sv
// Function
// - fast request beats normal request
// - enabled request taken at instruction end
// - multi-load may be interrupted midway
// - both interrupt requests are asynchronous
// - bus error or mmu fault raises abort
// - fetch abort taken at execute attempt
// - flush drops pending instruction abort
// - data abort after load/store attempt
// - aborts synchronous, interrupts async
// - sync abort records faulting instruction address
// - reset fetches from reset vector register
// - reset first, highest, never masked
// - of four mask bits, only fast and irq block their exceptions
module exc_entry
  import exc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // interrupt request pins from the controller
  input wire logic irq_pin,
  input wire logic fast_interrupt_request,
  // fetch side: a fetch completing, with its address and error
  input wire logic fetch_valid,
  input wire logic [ADDR_W-1:0] fetch_addr,
  input wire logic fetch_bus_err,
  input wire logic fetch_mmu_fault,
  // execute side
  input wire logic exec_start,
  input wire logic instr_done,
  input wire logic instr_multi_load,
  input wire logic [ADDR_W-1:0] exec_addr,
  input wire logic [ADDR_W-1:0] next_addr,
  input wire logic flush,
  // data side: access attempt result
  input wire logic mem_is_ldst,
  input wire logic data_resp,
  input wire logic data_bus_err,
  input wire logic data_mmu_fault,
  // mask update and reset vector setup
  input wire logic mask_we,
  input wire logic [3:0] mask_wdata,
  input wire logic rvbar_we,
  input wire logic [ADDR_W-1:0] rvbar_wdata,
  // results
  output logic exc_take,
  output exc_take_s exc_info_r,
  output logic [ADDR_W-1:0] vector_r,
  output logic [3:0] exception_mask_bits,
  output logic iabt_pending
);

  // pin synchronisers: first stage read only by second
  logic [1:0] irq_s1_r, irq_s2_r;
  // mask register and reset vector address register
  logic [3:0] mask_r;
  logic [ADDR_W-1:0] reset_vector_address_reg;
  // reset exception still owed after reset release
  logic rst_pend_r;
  // instruction abort marker travelling with a fetch
  logic iabt_r;
  logic [ADDR_W-1:0] iabt_addr_r;
  // request conditions
  logic fast_ok, irq_ok, iabt_hit, dabt_hit, at_boundary;
  exc_kind_e pick;

  // two-flop synchronisers for the asynchronous pins
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_s1_r <= 2'h0;
      irq_s2_r <= 2'h0;
    end
    else
    begin
      irq_s1_r <= {fast_interrupt_request, irq_pin};
      irq_s2_r <= irq_s1_r;
    end
  end

  // mask bits: software writes, entry masks interrupts
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      mask_r <= MASK_RST;
    else if (exc_take)
      mask_r <= mask_r | 4'h3; // handler runs with interrupts off
    else if (mask_we)
      mask_r <= mask_wdata;
  end

  // reset vector register: back to its default on every core reset
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reset_vector_address_reg <= RVBAR_RST;
    else if (rvbar_we)
      reset_vector_address_reg <= rvbar_wdata;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rst_pend_r <= 1'b1;
    else
      rst_pend_r <= 1'b0;
  end

  // mark faulting fetch; flush drops it
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      iabt_r <= 1'b0;
      iabt_addr_r <= '0;
    end
    else if (flush || exc_take)
      iabt_r <= 1'b0;
    else if (fetch_valid)
    begin
      // bus error or mmu fault on fetch
      iabt_r <= fetch_bus_err | fetch_mmu_fault;
      iabt_addr_r <= fetch_addr;
    end
    else if (exec_start)
      iabt_r <= 1'b0;
  end

  // request qualification
  always_comb
  begin
    fast_ok = irq_s2_r[1] & ~mask_r[MASK_FAST];
    irq_ok = irq_s2_r[0] & ~mask_r[MASK_IRQ];
    at_boundary = instr_done | instr_multi_load;
    // taken on execute attempt, before it runs
    iabt_hit = iabt_r & exec_start & ~flush;
    // data abort only after a load/store attempt
    dabt_hit = mem_is_ldst & data_resp &
               (data_bus_err | data_mmu_fault);
  end

  always_comb
  begin
    if (rst_pend_r)
      pick = EXC_RST;
    else if (dabt_hit)
      pick = EXC_DABT;
    else if (iabt_hit)
      pick = EXC_IABT;
    else if (fast_ok && at_boundary)
      pick = EXC_FAST;
    else if (irq_ok && at_boundary)
      pick = EXC_IRQ;
    else
      pick = EXC_NONE;
    exc_take = (pick != EXC_NONE);
  end

  // record taken exception and its vector
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      exc_info_r <= '{kind: EXC_NONE, sync_exc: 1'b0, ret_addr: '0};
      vector_r <= '0;
    end
    else if (exc_take)
    begin
      exc_info_r.kind <= pick;
      exc_info_r.sync_exc <= (pick == EXC_IABT) || (pick == EXC_DABT);
      // sync abort points at faulting instruction
      case (pick)
        EXC_IABT: exc_info_r.ret_addr <= iabt_addr_r;
        EXC_DABT: exc_info_r.ret_addr <= exec_addr;
        EXC_FAST, EXC_IRQ:
          exc_info_r.ret_addr <= instr_done ? next_addr : exec_addr;
        default: exc_info_r.ret_addr <= '0;
      endcase
      // reset fetch from reset vector register
      vector_r <= (pick == EXC_RST) ? reset_vector_address_reg : '0;
    end
  end

  // status outputs
  assign exception_mask_bits = mask_r;
  assign iabt_pending = iabt_r;

  // assertions
  property p_fast_first;
    @(posedge core_clk) disable iff (rst)
    (fast_ok && irq_ok && at_boundary && !rst_pend_r && !dabt_hit
     && !iabt_hit) |-> pick == EXC_FAST;
  endproperty
  a_fast_first: assert property (p_fast_first)
    else $error("normal request beat fast request");

  property p_masked;
    @(posedge core_clk) disable iff (rst)
    mask_r[MASK_IRQ] |-> pick != EXC_IRQ;
  endproperty
  a_masked: assert property (p_masked)
    else $error("masked normal request taken");

  property p_boundary;
    @(posedge core_clk) disable iff (rst)
    (pick == EXC_FAST || pick == EXC_IRQ) |-> at_boundary;
  endproperty
  a_boundary: assert property (p_boundary)
    else $error("interrupt taken mid instruction");

  property p_sync_class;
    @(posedge core_clk) disable iff (rst)
    (exc_take && (pick == EXC_FAST || pick == EXC_IRQ))
      |=> !exc_info_r.sync_exc;
  endproperty
  a_sync_class: assert property (p_sync_class)
    else $error("interrupt classed synchronous");

  sequence s_flushed_abort;
    iabt_r && flush;
  endsequence
  property p_flush_drop;
    @(posedge core_clk) disable iff (rst)
    s_flushed_abort |=> !iabt_r && pick != EXC_IABT;
  endproperty
  a_flush_drop: assert property (p_flush_drop)
    else $error("flushed instruction abort survived");

  property p_iabt_addr;
    @(posedge core_clk) disable iff (rst)
    (pick == EXC_IABT) |=> exc_info_r.sync_exc &&
      exc_info_r.ret_addr == $past(iabt_addr_r);
  endproperty
  a_iabt_addr: assert property (p_iabt_addr)
    else $error("abort return address wrong");

  property p_dabt_ldst;
    @(posedge core_clk) disable iff (rst)
    (pick == EXC_DABT) |-> mem_is_ldst && data_resp;
  endproperty
  a_dabt_ldst: assert property (p_dabt_ldst)
    else $error("data abort without load/store");

  property p_reset_first;
    @(posedge core_clk) $fell(rst) |-> pick == EXC_RST ##1
      vector_r == $past(reset_vector_address_reg);
  endproperty
  a_reset_first: assert property (p_reset_first)
    else $error("reset exception not taken first");

endmodule : exc_entry

// >>> hw/exc_pkg.sv
package exc_pkg;
  // width of addresses
  localparam int ADDR_W = 32;
  // exception_mask_bits positions
  localparam int MASK_DBG = 3;
  localparam int MASK_SERR = 2;
  localparam int MASK_IRQ = 1;
  localparam int MASK_FAST = 0;
  // reset value of the mask bits: all masked after reset
  localparam logic [3:0] MASK_RST = 4'hf;
  // default reset vector, arbitrary
  localparam logic [ADDR_W-1:0] RVBAR_RST = 32'h0000_0000;

  // exception kinds, one-hot
  typedef enum logic [5:0] {
    EXC_NONE = 6'b00_0001,
    EXC_RST  = 6'b00_0010,
    EXC_IABT = 6'b00_0100,
    EXC_DABT = 6'b00_1000,
    EXC_FAST = 6'b01_0000,
    EXC_IRQ  = 6'b10_0000
  } exc_kind_e;

  // one taken exception as reported to the core
  typedef struct packed {
    exc_kind_e kind;
    logic sync_exc;
    logic [ADDR_W-1:0] ret_addr;
  } exc_take_s;
endpackage : exc_pkg

// >>> tb/exc_irq_ctl.sv
// interrupt controller model: arbitration collapsed to one line per level
module exc_irq_ctl (
  // sources behind the controller
  input wire logic [3:0] src_fast,
  input wire logic [3:0] src_norm,
  // serialised request lines towards the core
  output logic fast_interrupt_request,
  output logic irq_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  assign fast_interrupt_request = |src_fast;
  assign irq_pin = |src_norm;
endmodule : exc_irq_ctl

// >>> tb/exception_entry_control_bench.sv
module exception_entry_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import exc_pkg::*;
  localparam int IW = $bits(exc_take_s);
  // stimulus, changed 10 ns after each rising edge
  logic core_clk, rst, fv, fbe, fmf, es, idn, iml, fl, ldst, dr, dbe, dmf;
  logic mwe, irq, fq, tk, ip, rvw;
  logic [ADDR_W-1:0] fa, ea, na, vec, rvd;
  logic [3:0] mwd, sf, sn, msk;
  exc_take_s info;
  int miscompares, n_checks;

  exc_irq_ctl ctl (.src_fast(sf), .src_norm(sn),
    .fast_interrupt_request(fq), .irq_pin(irq));
  // vector writes driven so a mid-run reset can show they are undone
  exc_entry dut (.core_clk(core_clk), .rst(rst), .irq_pin(irq),
    .fast_interrupt_request(fq), .fetch_valid(fv), .fetch_addr(fa),
    .fetch_bus_err(fbe), .fetch_mmu_fault(fmf), .exec_start(es),
    .instr_done(idn), .instr_multi_load(iml), .exec_addr(ea),
    .next_addr(na), .flush(fl), .mem_is_ldst(ldst), .data_resp(dr),
    .data_bus_err(dbe), .data_mmu_fault(dmf), .mask_we(mwe),
    .mask_wdata(mwd), .rvbar_we(rvw), .rvbar_wdata(rvd),
    .exc_take(tk), .exc_info_r(info), .vector_r(vec),
    .exception_mask_bits(msk), .iabt_pending(ip));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // expected record for a taken exception
  function automatic exc_take_s exp_info(exc_kind_e k, logic s,
    logic [ADDR_W-1:0] a);
    exp_info = '{kind: k, sync_exc: s, ret_addr: a};
  endfunction : exp_info

  task automatic chk(string nm, logic [IW-1:0] e, logic [IW-1:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // next cycle; one-cycle pulses drop back
  task automatic tick;
    @(posedge core_clk);
    #10;
    {fv, fbe, fmf, es, idn, iml, fl, ldst, dr, dbe, dmf, mwe, rvw} = '0;
  endtask : tick

  // look at the combinational take, then the record one edge later
  task automatic take(logic t, exc_kind_e k, logic s, logic [ADDR_W-1:0] a);
    #70;
    chk("exc_take", IW'(t), IW'(tk));
    tick();
    if (t)
      chk("exc_info_r", exp_info(k, s, a), info);
  endtask : take

  task automatic set_mask(logic [3:0] m);
    mwe = 1'b1;
    mwd = m;
    tick();
  endtask : set_mask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  // run is about 36 cycles; reaching the 2000-cycle limit is a hang
  initial
  begin
    #200000;
    miscompares++;
    complete_run();
  end

  initial
  begin
    {rst, fv, fbe, fmf, es, idn, iml, fl, ldst, dr, dbe, dmf, mwe} = 13'h1000;
    {fa, ea, na, rvd, mwd, sf, sn, rvw} = '0;
    void'($urandom(67467));
    repeat (8) @(posedge core_clk);
    #10 rst = 1'b0;
    #70 chk("exc_take", IW'(1), IW'(tk));
    tick();
    chk("kind", IW'(EXC_RST), IW'(info.kind));
    chk("vector_r", IW'(RVBAR_RST), IW'(vec));
    chk("mask", IW'(MASK_RST), IW'(msk));
    $display("test done: reset");
    // both lines pending, masks open: fast one wins
    set_mask(4'h0);
    sf = 4'(1 << $urandom_range(3));
    sn = 4'h1;
    repeat (3) tick();
    idn = 1'b1;
    na = $urandom;
    take(1'b1, EXC_FAST, 1'b0, na);
    chk("mask", IW'(4'h3), IW'(msk));
    // only the reset exception loads a vector
    chk("vector_r", IW'(0), IW'(vec));
    idn = 1'b1;
    take(1'b0, EXC_NONE, 1'b0, '0);
    set_mask(4'h1);
    idn = 1'b1;
    take(1'b1, EXC_IRQ, 1'b0, na);
    set_mask(4'h0);
    // cut multi-load: return to the interrupted instruction itself
    iml = 1'b1;
    ea = $urandom;
    take(1'b1, EXC_FAST, 1'b0, ea);
    {sf, sn} = '0;
    $display("test done: interrupts");
    for (int i = 0; i < 4; i++)
    begin
      fv = 1'b1;
      fa = $urandom;
      {fbe, fmf} = i[0] ? 2'b10 : 2'b01;
      tick();
      chk("iabt_pending", IW'(1), IW'(ip));
      fl = i[1];
      if (i[1])
        tick();
      es = 1'b1;
      take(!i[1], EXC_IABT, 1'b1, fa);
      ldst = !i[1];
      dr = 1'b1;
      {dbe, dmf} = i[0] ? 2'b10 : 2'b01;
      ea = $urandom;
      take(!i[1], EXC_DABT, 1'b1, ea);
    end
    $display("test done: aborts");
    // mid-run reset: a written vector register falls back to its default
    rvw = 1'b1;
    rvd = ~RVBAR_RST;
    tick();
    rst = 1'b1;
    tick();
    rst = 1'b0;
    take(1'b1, EXC_RST, 1'b0, '0);
    chk("vector_r", IW'(RVBAR_RST), IW'(vec));
    chk("mask", IW'(MASK_RST), IW'(msk));
    $display("test done: second reset");
    complete_run();
  end
endmodule : exception_entry_control_bench
